// ### sfq_consts.svh
// Offsets, field positions, reset values and sizes of the sample queue logic
`ifndef SFQ_CONSTS_SVH
`define SFQ_CONSTS_SVH
`define SFQ_OFF_EN1 8'h02
`define SFQ_OFF_EN2 8'h03
`define SFQ_OFF_WPTR 8'h04
`define SFQ_OFF_LOST 8'h05
`define SFQ_OFF_RPTR 8'h06
`define SFQ_OFF_DATA 8'h07
`define SFQ_OFF_CFG 8'h08
`define SFQ_BIT_AF_EN 7
`define SFQ_BIT_SUPPLY_EN 7
`define SFQ_BIT_CARDIO_EN 2
`define SFQ_BIT_AF_CLR 6
`define SFQ_BIT_AF_TYPE 5
`define SFQ_BIT_ROLL 4
`define SFQ_LSB_AF_THR 0
`define SFQ_AF_THR_W 4
`define SFQ_RST_BIT 1'h0
`define SFQ_RST_AF_THR 4'hF
`define SFQ_RST_BYTE 8'h00
`define SFQ_PTR_W 5
`define SFQ_MAX_ELEMS 4
`define SFQ_ELEM_BYTES 3
`endif

// ### sfq_pkg.sv
// Types shared by the sample queue pointer and flag logic
`include "sfq_consts.svh"
package sfq_pkg;
	// One register access from the serial interface
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfq_reg_req_type;

	// One queued sample, element 1 in the top bytes
	typedef logic [`SFQ_MAX_ELEMS*`SFQ_ELEM_BYTES*8-1:0] sfq_sample_type;

	// What an incoming sample does to the queue
	typedef enum logic [1:0] {
		SFQ_PUSH_NONE,
		SFQ_PUSH_STORE,
		SFQ_PUSH_ROLL,
		SFQ_PUSH_DROP
	} sfq_push_type;
endpackage

// ### sfq_sat_counter.sv
// Saturating counter of samples lost on a full queue
`timescale 1ns/1ps
module sfq_sat_counter #(
	parameter int W = 5
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         sys_rst,
	// Control
	input  wire logic         clear,
	input  wire logic         incr,
	// Count
	output logic [W-1:0]      count_ff
);
	localparam logic [W-1:0] MAX_CNT = '1;

	if (W < 1) begin : g_bad_width
		$error("sfq_sat_counter: W must be at least 1");
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Count up, hold at all ones
	always_ff @(posedge clk) begin
		if (sys_rst || clear) begin
			count_ff <= '0;
		end else if (incr && count_ff != MAX_CNT) begin
			count_ff <= count_ff + W'(1);
		end
	end

	a_lost_saturates: assert property (count_ff == MAX_CNT && !clear |=> count_ff == MAX_CNT)
		else $error("lost count left saturation");
	a_lost_counts_up: assert property (incr && !clear && count_ff != MAX_CNT
		|=> count_ff == $past(count_ff) + W'(1))
		else $error("lost count did not advance");
endmodule

// ### sfq_af_flag.sv
// Almost-full flag with repeat or single assertion and selectable clearing
`timescale 1ns/1ps
`include "sfq_consts.svh"
module sfq_af_flag #(
	parameter int DEPTH = 32,
	parameter int CNT_W = 6
) (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	// Queue state
	input  wire logic [CNT_W-1:0]         nxtCount,
	input  wire logic                     pushDone,
	// Configuration
	input  wire logic [`SFQ_AF_THR_W-1:0] threshold,
	input  wire logic                     singleMode,
	input  wire logic                     clearOnData,
	// Clearing reads
	input  wire logic                     statusRead,
	input  wire logic                     dataRead,
	// Flag
	output logic                          flag_ff
);
	logic             condPrev_ff;
	logic             cond;
	logic             setNow;
	logic             clrNow;
	logic [CNT_W-1:0] limit;

	// Depth must exceed the largest threshold and fit the count
	if (DEPTH <= 15 || DEPTH > (1 << CNT_W) - 1) begin : g_bad_depth
		$error("sfq_af_flag: DEPTH must be 16 up to 2**CNT_W-1");
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Fill level that raises the flag: depth less the free space
	assign limit = CNT_W'(DEPTH) - CNT_W'(threshold);
	assign cond = nxtCount >= limit;
	// Repeat mode raises on each push, single mode on entry only
	assign setNow = singleMode ? (cond && !condPrev_ff) : (cond && pushDone);
	assign clrNow = statusRead || (clearOnData && dataRead);

	// Condition as of the previous cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			condPrev_ff <= 1'b0;
		end else begin
			condPrev_ff <= cond;
		end
	end

	// Sticky flag, a set beats a clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			flag_ff <= 1'b0;
		end else if (setNow) begin
			flag_ff <= 1'b1;
		end else if (clrNow) begin
			flag_ff <= 1'b0;
		end
	end

	a_af_data_keep: assert property (flag_ff && dataRead && !clearOnData && !statusRead
		|=> flag_ff)
		else $error("almost-full cleared by data read");
	a_af_repeat: assert property (!singleMode && pushDone && cond |=> flag_ff)
		else $error("almost-full not raised on push");
	a_af_single: assert property (singleMode && condPrev_ff && cond && !flag_ff
		|=> !flag_ff)
		else $error("almost-full raised again in single mode");
endmodule

// ### sfq_pointer_flags.sv
// Pointer, lost-sample and almost-full logic of the 32-sample queue
`timescale 1ns/1ps
`include "sfq_consts.svh"
module sfq_pointer_flags
	import sfq_pkg::*;
#(
	parameter int PTR_W     = `SFQ_PTR_W,
	parameter int MAX_ELEMS = `SFQ_MAX_ELEMS
) (
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            sys_rst,
	// Register access from the serial interface
	input  wire sfq_reg_req_type regReq,
	input  wire logic            statusRead,
	output logic [7:0]           regRdata_ff,
	// Acquisition side
	input  wire logic            pushValid,
	input  wire sfq_sample_type  pushSample,
	input  wire logic [2:0]      elementCount,
	input  wire logic            proxMode,
	input  wire logic            queueEnable,
	// Event flags held elsewhere
	input  wire logic            supplyRangeEvent,
	input  wire logic            cardioSampleEvent,
	// Flags
	output logic                 nearlyFullFlag,
	output logic                 eventIrq_ff
);
	localparam int DEPTH = 1 << PTR_W;
	localparam int CNT_W = PTR_W + 1;
	localparam int SBITS = $bits(sfq_sample_type);
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

	// Elaboration checks on the shape
	if (PTR_W < 4 || PTR_W > 8) begin : g_bad_ptr
		$error("sfq_pointer_flags: PTR_W must be 4 to 8");
	end
	if (MAX_ELEMS != `SFQ_MAX_ELEMS) begin : g_bad_elems
		$error("sfq_pointer_flags: MAX_ELEMS must match the sample type");
	end

	// Address match of one register access
	function automatic logic regHit(input sfq_reg_req_type r, input logic [7:0] off);
		return r.addr == off;
	endfunction

	// Bytes in one sample for a given element count
	function automatic logic [3:0] sampleBytes(input logic [2:0] n);
		return 4'(n) * 4'(`SFQ_ELEM_BYTES);
	endfunction

	// One byte of a sample, first byte from the top
	function automatic logic [7:0] sampleByte(input sfq_sample_type s, input logic [3:0] i);
		return s[(SBITS - 1) - 8 * int'(i) -: 8];
	endfunction

	// Configuration and enable registers
	logic                     afEnable_ff;
	logic                     supplyRangeEventEnable_ff;
	logic                     cardioSampleEventEnable_ff;
	logic                     afClearOption_ff;
	logic                     afType_ff;
	logic                     rollOnFull_ff;
	logic [`SFQ_AF_THR_W-1:0] afThreshold_ff;

	// Queue state
	sfq_sample_type   mem_ff [DEPTH];
	logic [PTR_W-1:0] queueWriteIndex_ff;
	logic [PTR_W-1:0] queueReadIndex_ff;
	logic [PTR_W-1:0] nxt_queueWriteIndex;
	logic [PTR_W-1:0] nxt_queueReadIndex;
	logic [CNT_W-1:0] count_ff;
	logic [CNT_W-1:0] nxt_count;
	logic [3:0]       byteIdx_ff;
	logic             enablePrev_ff;
	logic [PTR_W-1:0] lostSampleCount;

	// Decoded strobes
	logic         flush;
	logic         empty;
	logic         full;
	logic         dataRead;
	logic         validDataRead;
	logic         popNow;
	logic         wrPtrWrite;
	logic         rdPtrWrite;
	logic         ptrWrite;
	logic         pushDone;
	logic [3:0]   lastByte;
	logic [PTR_W-1:0] ptrDiff;
	sfq_push_type pushAct;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Access and queue state decode
	assign flush = queueEnable && !enablePrev_ff;
	assign empty = count_ff == '0;
	assign full = count_ff == FULL_CNT;
	assign dataRead = regReq.rd && regHit(regReq, `SFQ_OFF_DATA);
	assign validDataRead = dataRead && !empty && elementCount != 3'h0;
	assign lastByte = sampleBytes(elementCount) - 4'h1;
	assign popNow = validDataRead && byteIdx_ff == lastByte;
	assign wrPtrWrite = regReq.wr && regHit(regReq, `SFQ_OFF_WPTR);
	assign rdPtrWrite = regReq.wr && regHit(regReq, `SFQ_OFF_RPTR);
	assign ptrWrite = (wrPtrWrite || rdPtrWrite) && !flush;
	assign pushDone = pushAct == SFQ_PUSH_STORE || pushAct == SFQ_PUSH_ROLL;
	assign ptrDiff = nxt_queueWriteIndex - nxt_queueReadIndex;

	// Fate of an incoming sample
	always_comb begin
		if (!queueEnable || !pushValid || flush) begin
			pushAct = SFQ_PUSH_NONE;
		end else if (!full || popNow) begin
			pushAct = SFQ_PUSH_STORE;
		end else if (rollOnFull_ff || proxMode) begin
			pushAct = SFQ_PUSH_ROLL;
		end else begin
			pushAct = SFQ_PUSH_DROP;
		end
	end

	// Next write index
	always_comb begin
		if (flush) begin
			nxt_queueWriteIndex = '0;
		end else if (wrPtrWrite) begin
			nxt_queueWriteIndex = regReq.wdata[PTR_W-1:0];
		end else if (pushDone) begin
			nxt_queueWriteIndex = queueWriteIndex_ff + PTR_W'(1);
		end else begin
			nxt_queueWriteIndex = queueWriteIndex_ff;
		end
	end

	// Next read index
	always_comb begin
		if (flush) begin
			nxt_queueReadIndex = '0;
		end else if (rdPtrWrite) begin
			nxt_queueReadIndex = regReq.wdata[PTR_W-1:0];
		end else if (pushAct == SFQ_PUSH_ROLL || popNow) begin
			nxt_queueReadIndex = queueReadIndex_ff + PTR_W'(1);
		end else begin
			nxt_queueReadIndex = queueReadIndex_ff;
		end
	end

	// Next occupancy, equal indices read as full only if it was full
	always_comb begin
		if (flush) begin
			nxt_count = '0;
		end else if (ptrWrite) begin
			nxt_count = (ptrDiff == '0 && full) ? FULL_CNT : CNT_W'(ptrDiff);
		end else begin
			case (pushAct)
				SFQ_PUSH_STORE: nxt_count = count_ff + CNT_W'(!popNow);
				SFQ_PUSH_ROLL:  nxt_count = count_ff;
				default:        nxt_count = count_ff - CNT_W'(popNow);
			endcase
		end
	end

	// Index and occupancy registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			queueWriteIndex_ff <= '0;
			queueReadIndex_ff <= '0;
			count_ff <= '0;
		end else begin
			queueWriteIndex_ff <= nxt_queueWriteIndex;
			queueReadIndex_ff <= nxt_queueReadIndex;
			count_ff <= nxt_count;
		end
	end

	// Byte position inside the sample being read
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			byteIdx_ff <= 4'h0;
		end else if (flush || rdPtrWrite || pushAct == SFQ_PUSH_ROLL) begin
			byteIdx_ff <= 4'h0;
		end else if (validDataRead) begin
			byteIdx_ff <= popNow ? 4'h0 : byteIdx_ff + 4'h1;
		end
	end

	// Enable level of the previous cycle, for the flush edge
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			enablePrev_ff <= 1'b0;
		end else begin
			enablePrev_ff <= queueEnable;
		end
	end

	// Sample storage, one slot per index
	always_ff @(posedge clk) begin
		if (pushDone) begin
			mem_ff[queueWriteIndex_ff] <= pushSample;
		end
	end

	// Lost samples, cleared by a flush
	sfq_sat_counter #(
		.W (PTR_W)
	) u_lost (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.clear    (flush),
		.incr     (pushAct == SFQ_PUSH_ROLL || pushAct == SFQ_PUSH_DROP),
		.count_ff (lostSampleCount)
	);

	// Almost-full flag
	sfq_af_flag #(
		.DEPTH (DEPTH),
		.CNT_W (CNT_W)
	) u_af (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.nxtCount    (nxt_count),
		.pushDone    (pushDone),
		.threshold   (afThreshold_ff),
		.singleMode  (afType_ff),
		.clearOnData (afClearOption_ff),
		.statusRead  (statusRead),
		.dataRead    (dataRead),
		.flag_ff     (nearlyFullFlag)
	);

	// Enable registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			afEnable_ff <= `SFQ_RST_BIT;
			supplyRangeEventEnable_ff <= `SFQ_RST_BIT;
			cardioSampleEventEnable_ff <= `SFQ_RST_BIT;
		end else if (regReq.wr && regHit(regReq, `SFQ_OFF_EN1)) begin
			afEnable_ff <= regReq.wdata[`SFQ_BIT_AF_EN];
		end else if (regReq.wr && regHit(regReq, `SFQ_OFF_EN2)) begin
			supplyRangeEventEnable_ff <= regReq.wdata[`SFQ_BIT_SUPPLY_EN];
			cardioSampleEventEnable_ff <= regReq.wdata[`SFQ_BIT_CARDIO_EN];
		end
	end

	// Queue configuration register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			afClearOption_ff <= `SFQ_RST_BIT;
			afType_ff <= `SFQ_RST_BIT;
			rollOnFull_ff <= `SFQ_RST_BIT;
			afThreshold_ff <= `SFQ_RST_AF_THR;
		end else if (regReq.wr && regHit(regReq, `SFQ_OFF_CFG)) begin
			afClearOption_ff <= regReq.wdata[`SFQ_BIT_AF_CLR];
			afType_ff <= regReq.wdata[`SFQ_BIT_AF_TYPE];
			rollOnFull_ff <= regReq.wdata[`SFQ_BIT_ROLL];
			afThreshold_ff <= regReq.wdata[`SFQ_LSB_AF_THR +: `SFQ_AF_THR_W];
		end
	end

	// Read data, unmapped and empty reads give zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			regRdata_ff <= `SFQ_RST_BYTE;
		end else if (regReq.rd) begin
			case (regReq.addr)
				`SFQ_OFF_EN1:  regRdata_ff <= 8'(afEnable_ff) << `SFQ_BIT_AF_EN;
				`SFQ_OFF_EN2:  regRdata_ff <= (8'(supplyRangeEventEnable_ff) << `SFQ_BIT_SUPPLY_EN)
					| (8'(cardioSampleEventEnable_ff) << `SFQ_BIT_CARDIO_EN);
				`SFQ_OFF_WPTR: regRdata_ff <= 8'(queueWriteIndex_ff);
				`SFQ_OFF_LOST: regRdata_ff <= 8'(lostSampleCount);
				`SFQ_OFF_RPTR: regRdata_ff <= 8'(queueReadIndex_ff);
				`SFQ_OFF_DATA: regRdata_ff <= validDataRead
					? sampleByte(mem_ff[queueReadIndex_ff], byteIdx_ff) : `SFQ_RST_BYTE;
				`SFQ_OFF_CFG:  regRdata_ff <= (8'(afClearOption_ff) << `SFQ_BIT_AF_CLR)
					| (8'(afType_ff) << `SFQ_BIT_AF_TYPE)
					| (8'(rollOnFull_ff) << `SFQ_BIT_ROLL)
					| (8'(afThreshold_ff) << `SFQ_LSB_AF_THR);
				default:       regRdata_ff <= `SFQ_RST_BYTE;
			endcase
		end
	end

	// Enabled events onto the one interrupt line
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			eventIrq_ff <= 1'b0;
		end else begin
			eventIrq_ff <= (nearlyFullFlag && afEnable_ff)
				|| (supplyRangeEvent && supplyRangeEventEnable_ff)
				|| (cardioSampleEvent && cardioSampleEventEnable_ff);
		end
	end

	// Sequences of the push and flush behaviour
	sequence s_flush;
		queueEnable && !enablePrev_ff;
	endsequence
	sequence s_full_push;
		queueEnable && enablePrev_ff && pushValid && full && !popNow && !ptrWrite;
	endsequence

	a_flush_zero: assert property (s_flush |=> queueWriteIndex_ff == '0
		&& queueReadIndex_ff == '0 && count_ff == '0)
		else $error("flush did not restart at zero");
	a_disabled_hold: assert property (!queueEnable && !ptrWrite && !dataRead
		|=> queueWriteIndex_ff == $past(queueWriteIndex_ff) && count_ff == $past(count_ff))
		else $error("queue changed while disabled");
	a_store_adv: assert property (queueEnable && enablePrev_ff && pushValid && !full
		&& !ptrWrite |=> queueWriteIndex_ff == $past(queueWriteIndex_ff) + PTR_W'(1))
		else $error("write index did not advance");
	a_roll_both: assert property (s_full_push ##0 (rollOnFull_ff || proxMode)
		|=> queueReadIndex_ff == $past(queueReadIndex_ff) + PTR_W'(1)
		&& queueWriteIndex_ff == $past(queueWriteIndex_ff) + PTR_W'(1) && full)
		else $error("roll on full did not move both indices");
	a_stop_hold: assert property (s_full_push ##0 (!rollOnFull_ff && !proxMode)
		|=> queueWriteIndex_ff == $past(queueWriteIndex_ff) && full)
		else $error("stop on full moved write index");
	a_pop_adv: assert property (popNow && !flush && !rdPtrWrite && pushAct != SFQ_PUSH_ROLL
		|=> queueReadIndex_ff == $past(queueReadIndex_ff) + PTR_W'(1))
		else $error("read index did not advance on pop");
	a_rewind_take: assert property (rdPtrWrite && !flush
		|=> queueReadIndex_ff == $past(regReq.wdata[PTR_W-1:0]) && byteIdx_ff == 4'h0)
		else $error("read index rewind not taken");
	a_empty_read: assert property (dataRead && empty && !flush && !rdPtrWrite
		|=> queueReadIndex_ff == $past(queueReadIndex_ff) && regRdata_ff == 8'h00)
		else $error("empty read disturbed read index");
	a_count_bound: assert property (count_ff <= FULL_CNT)
		else $error("occupancy above depth");
	a_supply_irq: assert property (supplyRangeEvent && supplyRangeEventEnable_ff
		|=> eventIrq_ff)
		else $error("enabled supply event not on interrupt");
endmodule

// ### sfq_host_model.sv
// Host processor model issuing register accesses and status reads
`timescale 1ns/1ps
module sfq_host_model
	import sfq_pkg::*;
(
	// Clock
	input  wire logic       clk,
	// Register access
	input  wire logic [7:0] regRdata_ff,
	output sfq_reg_req_type regReq,
	output logic            statusRead
);
	// Idle request lines at time zero
	initial begin
		regReq = '0;
		statusRead = 1'b0;
	end

	// Drop strobes, scramble stale address and data
	task automatic release_bus();
		regReq.rd = 1'b0;
		regReq.wr = 1'b0;
		regReq.addr = ~regReq.addr;
		regReq.wdata = ~regReq.wdata;
	endtask

	// One write, held up to its sampling edge
	task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk);
		#1;
		regReq = '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
		@(posedge clk);
		#1;
		release_bus();
	endtask

	// One read, data taken after the sampling edge
	task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clk);
		#1;
		regReq = '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
		@(posedge clk);
		#1;
		data = regRdata_ff;
		release_bus();
	endtask

	// Status register read pulse
	task automatic status_read();
		@(posedge clk);
		#1;
		statusRead = 1'b1;
		@(posedge clk);
		#1;
		statusRead = 1'b0;
	endtask
endmodule

// ### sfq_pointer_flags_bench.sv
// Self-checking bench of the sample queue pointer and flag logic
`timescale 1ns/1ps
`include "sfq_consts.svh"
module sfq_pointer_flags_bench
	import sfq_pkg::*;
;
	localparam logic [7:0] EN1 = `SFQ_OFF_EN1;
	localparam logic [7:0] EN2 = `SFQ_OFF_EN2;
	localparam logic [7:0] WP  = `SFQ_OFF_WPTR;
	localparam logic [7:0] LST = `SFQ_OFF_LOST;
	localparam logic [7:0] RP  = `SFQ_OFF_RPTR;
	localparam logic [7:0] DAT = `SFQ_OFF_DATA;
	localparam logic [7:0] CFG = `SFQ_OFF_CFG;

	logic            clk;
	logic            sys_rst;
	sfq_reg_req_type regReq;
	logic            statusRead;
	logic [7:0]      regRdata_ff;
	logic            pushValid;
	sfq_sample_type  pushSample;
	logic [2:0]      elementCount;
	logic            proxMode;
	logic            queueEnable;
	logic            supplyRangeEvent;
	logic            cardioSampleEvent;
	logic            nearlyFullFlag;
	logic            eventIrq_ff;
	int              n_errors;
	int              compares;

	sfq_pointer_flags sfq_pointer_flags_i (
		.clk(clk), .sys_rst(sys_rst), .regReq(regReq), .statusRead(statusRead),
		.regRdata_ff(regRdata_ff), .pushValid(pushValid), .pushSample(pushSample),
		.elementCount(elementCount), .proxMode(proxMode), .queueEnable(queueEnable),
		.supplyRangeEvent(supplyRangeEvent), .cardioSampleEvent(cardioSampleEvent),
		.nearlyFullFlag(nearlyFullFlag), .eventIrq_ff(eventIrq_ff)
	);

	sfq_host_model sfq_host_model_i (
		.clk(clk), .regRdata_ff(regRdata_ff), .regReq(regReq), .statusRead(statusRead)
	);

	// Clock at 250 MHz
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Verdict and end of run
	task automatic print_verdict();
		if (n_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Byte compare
	task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Single-bit compare
	task automatic chk1(input string name, input logic exp, input logic got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %b seen %b", name, exp, got);
		end
	endtask

	// Register read and compare
	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] d;
		sfq_host_model_i.reg_read(addr, d);
		chk8($sformatf("reg %h", addr), exp, d);
	endtask

	// Read one sample of one element and compare its bytes
	task automatic rd_sample(input logic [7:0] idx);
		rd_chk(DAT, 8'h5A);
		rd_chk(DAT, idx);
		rd_chk(DAT, 8'hC3);
	endtask

	// Push n samples back to back, numbered from base
	task automatic push_n(input int base, input int n);
		for (int k = 0; k < n; k++) begin
			@(posedge clk);
			#1;
			pushValid = 1'b1;
			pushSample = {8'h5A, 8'(base + k), 8'hC3, 72'h0};
		end
		@(posedge clk);
		#1;
		pushValid = 1'b0;
	endtask

	// Queue enable low then high, flushing the queue
	task automatic flush_q();
		@(posedge clk);
		#1;
		queueEnable = 1'b0;
		@(posedge clk);
		#1;
		queueEnable = 1'b1;
		@(posedge clk);
		#1;
	endtask

	// Two edges for a registered output
	task automatic wait2();
		repeat (2) @(posedge clk);
		#1;
	endtask

	// Reset values, unmapped and empty reads
	task automatic t_reset_values();
		rd_chk(EN2, 8'h00);
		rd_chk(WP, 8'h00);
		rd_chk(LST, 8'h00);
		rd_chk(RP, 8'h00);
		rd_chk(CFG, 8'h0F);
		rd_chk(DAT, 8'h00);
		rd_chk(RP, 8'h00);
		rd_chk(8'h0A, 8'h00);
	endtask

	// Event enables gate the interrupt
	task automatic t_events();
		sfq_host_model_i.reg_write(EN2, 8'hFF);
		rd_chk(EN2, 8'h84);
		supplyRangeEvent = 1'b1;
		wait2();
		chk1("irq supply", 1'b1, eventIrq_ff);
		supplyRangeEvent = 1'b0;
		cardioSampleEvent = 1'b1;
		wait2();
		chk1("irq cardio", 1'b1, eventIrq_ff);
		sfq_host_model_i.reg_write(EN2, 8'h00);
		supplyRangeEvent = 1'b1;
		wait2();
		chk1("irq masked", 1'b0, eventIrq_ff);
		supplyRangeEvent = 1'b0;
		cardioSampleEvent = 1'b0;
	endtask

	// Push, byte order, pop and rewind
	task automatic t_push_read();
		flush_q();
		push_n(0, 3);
		rd_chk(WP, 8'h03);
		rd_sample(8'h00);
		rd_chk(RP, 8'h01);
		rd_sample(8'h01);
		sfq_host_model_i.reg_write(RP, 8'h00);
		rd_sample(8'h00);
		rd_chk(RP, 8'h01);
	endtask

	// Stop on full, lost count saturation
	task automatic t_stop_full();
		flush_q();
		push_n(0, 34);
		rd_chk(WP, 8'h00);
		rd_chk(LST, 8'h02);
		push_n(40, 40);
		rd_chk(LST, 8'h1F);
		sfq_host_model_i.reg_write(LST, 8'h00);
		rd_chk(LST, 8'h1F);
		rd_sample(8'h00);
	endtask

	// Roll on full by bit and by proximity mode
	task automatic t_roll();
		sfq_host_model_i.reg_write(CFG, 8'h1F);
		flush_q();
		push_n(0, 33);
		rd_chk(WP, 8'h01);
		rd_chk(RP, 8'h01);
		rd_chk(LST, 8'h01);
		rd_sample(8'h01);
		sfq_host_model_i.reg_write(CFG, 8'h0F);
		proxMode = 1'b1;
		flush_q();
		push_n(0, 33);
		rd_chk(WP, 8'h01);
		rd_chk(RP, 8'h01);
		rd_chk(LST, 8'h01);
		proxMode = 1'b0;
	endtask

	// Almost-full threshold, repeat, single, clear option, enable
	task automatic t_nearly_full();
		flush_q();
		sfq_host_model_i.status_read();
		push_n(0, 16);
		chk1("flag 16", 1'b0, nearlyFullFlag);
		push_n(16, 1);
		chk1("flag 17", 1'b1, nearlyFullFlag);
		sfq_host_model_i.reg_write(EN1, 8'h80);
		rd_chk(EN1, 8'h80);
		wait2();
		chk1("irq full", 1'b1, eventIrq_ff);
		sfq_host_model_i.status_read();
		chk1("flag clr", 1'b0, nearlyFullFlag);
		push_n(17, 1);
		chk1("flag rpt", 1'b1, nearlyFullFlag);
		rd_chk(DAT, 8'h5A);
		chk1("flag keep", 1'b1, nearlyFullFlag);
		sfq_host_model_i.reg_write(CFG, 8'h4F);
		rd_chk(DAT, 8'h00);
		chk1("flag data", 1'b0, nearlyFullFlag);
		sfq_host_model_i.reg_write(CFG, 8'h2F);
		flush_q();
		sfq_host_model_i.status_read();
		push_n(0, 17);
		chk1("flag once", 1'b1, nearlyFullFlag);
		sfq_host_model_i.status_read();
		push_n(17, 1);
		chk1("flag no rpt", 1'b0, nearlyFullFlag);
		sfq_host_model_i.reg_write(EN1, 8'h00);
		sfq_host_model_i.reg_write(CFG, 8'h0F);
	endtask

	// Disabled queue ignores pushes, keeps contents
	task automatic t_disable();
		flush_q();
		push_n(0, 2);
		queueEnable = 1'b0;
		push_n(2, 2);
		rd_chk(WP, 8'h02);
		rd_sample(8'h00);
	endtask

	// Two-element samples, lower threshold, empty after index write
	task automatic t_elements();
		sfq_host_model_i.reg_write(CFG, 8'h03);
		elementCount = 3'd2;
		flush_q();
		sfq_host_model_i.status_read();
		push_n(0, 28);
		chk1("flag 28", 1'b0, nearlyFullFlag);
		push_n(28, 1);
		chk1("flag 29", 1'b1, nearlyFullFlag);
		rd_sample(8'h00);
		rd_chk(DAT, 8'h00);
		rd_chk(DAT, 8'h00);
		rd_chk(DAT, 8'h00);
		rd_chk(RP, 8'h01);
		elementCount = 3'd0;
		rd_chk(DAT, 8'h00);
		rd_chk(RP, 8'h01);
		elementCount = 3'd1;
		sfq_host_model_i.reg_write(RP, 8'h1D);
		rd_chk(DAT, 8'h00);
		rd_chk(RP, 8'h1D);
		sfq_host_model_i.reg_write(CFG, 8'h0F);
	endtask

	// Watchdog
	initial begin
		#200000;
		n_errors++;
		print_verdict();
	end

	// Main sequence
	initial begin
		n_errors = 0;
		compares = 0;
		sys_rst = 1'b1;
		pushValid = 1'b0;
		pushSample = '0;
		elementCount = 3'd1;
		proxMode = 1'b0;
		queueEnable = 1'b0;
		supplyRangeEvent = 1'b0;
		cardioSampleEvent = 1'b0;
		repeat (5) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		t_reset_values();
		t_events();
		t_push_read();
		t_stop_full();
		t_roll();
		t_nearly_full();
		t_disable();
		t_elements();
		print_verdict();
	end
endmodule
